// *** clpl_pkg.sv ***
// shared constants and types for the calibrator program loader
package clpl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// apb register offsets (byte addresses)
	localparam logic [7:0] REG_MAP_LO = 8'h00;
	localparam logic [7:0] REG_MAP_HI = 8'h04;
	localparam logic [7:0] REG_CTRL_ORDER = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_INT_STAT = 8'h10;
	localparam logic [7:0] REG_INT_MASK = 8'h14;
	localparam logic [7:0] REG_WORD_LO = 8'h18;
	localparam logic [7:0] REG_WORD_HI = 8'h1C;

	// reset values: identity address map, control lines in natural order
	localparam logic [63:0] MAP_RST = 64'hFEDCBA9876543210;
	localparam logic [7:0] CTRL_ORDER_RST = 8'hE4;
	localparam logic [2:0] INT_MASK_RST = 3'h0;

	// interrupt status bit positions
	localparam int INT_STROBE = 0;
	localparam int INT_XFER = 1;
	localparam int INT_SETTLED = 2;

	// status register bit positions
	localparam int ST_READY = 0;
	localparam int ST_PENDING = 1;

	////////////////////////////////////////////////////////////////////////////////
	// input register element codes, as steered by the address map
	localparam logic [3:0] EL_AMP_OVR = 4'h0;
	localparam logic [3:0] EL_AMP_TOP = 4'h1;
	localparam logic [3:0] EL_AMP_BOTTOM = 4'h6;
	localparam logic [3:0] EL_AMP_RNG = 4'h7;
	localparam logic [3:0] EL_FRQ_OVR = 4'h8;
	localparam logic [3:0] EL_FRQ_TOP = 4'h9;
	localparam logic [3:0] EL_FRQ_BOTTOM = 4'hC;
	localparam logic [3:0] EL_FRQ_RNG = 4'hD;
	localparam logic [3:0] EL_CTRL = 4'hE;
	localparam logic [3:0] EL_XFER = 4'hF;

	// lowest frequency range code selects the long settle time
	localparam logic [2:0] FRQ_RNG_LOWEST = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// settle timing
	localparam longint CLK_HZ = 10000000;
	localparam longint SETTLE_SHORT_MS = 500;
	localparam longint SETTLE_LONG_MS = 4000;
	localparam int SETTLE_SHORT_CYC = int'(SETTLE_SHORT_MS * CLK_HZ / 1000);
	localparam int SETTLE_LONG_CYC = int'(SETTLE_LONG_MS * CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////////////
	// 54-bit program word; digit index 0 is the bottom digit
	typedef struct packed {
		logic [1:0] spare;
		logic [3:0] ctrl;
		logic frq_ovr;
		logic [2:0] frq_rng;
		logic [3:0][3:0] frq_dig;
		logic amp_ovr;
		logic [2:0] amp_rng;
		logic [5:0][3:0] amp_dig;
	} clpl_word_t;

	// control element bit positions within ctrl
	localparam int CTL_SENSE = 0;
	localparam int CTL_PHASE = 1;
	localparam int CTL_REMOTE = 2;
	localparam int CTL_STANDBY = 3;

endpackage : clpl_pkg

// *** clpl_decode.sv ***
// address decoder and strap map from byte address to element enable
module clpl_decode (
	input wire logic [3:0] byte_addr,
	input wire logic [63:0] addr_map,
	output logic [15:0] elem_en
);

	logic [15:0] addr_onehot;

	// plain 1-of-16 decode of the byte address
	assign addr_onehot = 16'h0001 << byte_addr;

	////////////////////////////////////////////////////////////////////////////////
	// an element is enabled when the addressed decoder output is strapped to it;
	// only one decoder output is live, so at most one element loads
	for (genvar e = 0; e < 16; e++) begin : g_elem
		logic [15:0] hit;
		for (genvar a = 0; a < 16; a++) begin : g_addr
			assign hit[a] = addr_onehot[a] && (addr_map[a*4 +: 4] == 4'(e));
		end
		assign elem_en[e] = |hit;
	end

endmodule : clpl_decode

// *** clpl_settle.sv ***
// settle timer behind the ready flag
module clpl_settle #(
	parameter int SHORT_CYC = clpl_pkg::SETTLE_SHORT_CYC,
	parameter int LONG_CYC = clpl_pkg::SETTLE_LONG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic long_sel,
	output logic ready
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [31:0] load_val;

	// a fresh strobe restarts the full settle time
	assign load_val = long_sel ? 32'(LONG_CYC) : 32'(SHORT_CYC);
	assign cnt_nxt = start ? load_val : ((cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0);

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
			ready <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			ready <= (cnt_nxt == 32'h0);
		end
	end

endmodule : clpl_settle

// *** clpl_loader.sv ***
// program word loader: strobed nibble input register, transfer commit, apb control
//
// Notes on behaviour
// RULE1 - amplitude range codes 1 to 7 pick the seven decades, millivolt upward
// RULE2 - amplitude range code zero selects the millivolt range, like code 1
// RULE3 - range elements take only the three low data lines
// RULE4 - overrange elements take only the lowest data line
// RULE5 - unused data lines of range and overrange elements change nothing
// RULE6 - byte address decodes one-hot; one element loads per strobe
// RULE7 - address 15 by default is the transfer command, carrying no data
// RULE8 - by default control is 14, frequency range 13, bottom frequency digit 12
// RULE9 - by default 0 amplitude overrange, 1-6 amplitude digits, 7 amplitude range
// RULE10 - by default 8 frequency overrange, 9-12 frequency digits top to bottom
// RULE11 - control holds sense, phase lock, remote, standby; bit order is configurable
// RULE12 - address map is configurable; fields keep fixed word positions
// RULE13 - with ranges swapped, source uses 13 for amplitude, 7 for frequency range
// RULE14 - source holds address and data during a low strobe of 800 ns or more
// RULE15 - loaded data reaches the output only on the transfer command
// RULE16 - elements not addressed keep their contents
// RULE17 - ready low 0.5 s after strobe, 4.0 s on the lowest frequency range
// RULE18 - reset clears all elements, giving the lowest amplitude range
//
// Register access over APB and the placing of the registers were decided locally.
module clpl_loader #(
	parameter int SHORT_CYC = clpl_pkg::SETTLE_SHORT_CYC,
	parameter int LONG_CYC = clpl_pkg::SETTLE_LONG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] byte_addr,
	input wire logic [3:0] prog_data,
	input wire logic addr_strobe_n,
	output clpl_pkg::clpl_word_t prog_word,
	output logic [6:0] amp_decade,
	output logic ready_flag,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	clpl_pkg::clpl_word_t in_r;
	clpl_pkg::clpl_word_t in_nxt;
	logic [63:0] map_r;
	logic [7:0] order_r;
	logic [2:0] int_r;
	logic [2:0] int_nxt;
	logic [2:0] mask_r;
	logic strb_q_r;
	logic pending_r;
	logic ready_q_r;
	logic [31:0] rdata_nxt;
	logic rerr_nxt;

	// link side wires
	logic strb_fall;
	logic strb_rise;
	logic [15:0] elem_en;
	logic load;
	logic xfer;
	logic settle_ready;
	logic [3:0] ctrl_val;
	logic [2:0] events;

	// bus side wires
	logic apb_access;
	logic apb_done;
	logic wr_fire;
	logic sel_map_lo;
	logic sel_map_hi;
	logic sel_order;
	logic sel_status;
	logic sel_int;
	logic sel_mask;
	logic sel_word_lo;
	logic sel_word_hi;
	logic sel_any;

	////////////////////////////////////////////////////////////////////////////////
	// strobe edges; inputs are synchronous, so one history flop suffices
	// limitation: an asynchronous source would need two flops ahead of this one
	assign strb_fall = strb_q_r && !addr_strobe_n;
	assign strb_rise = !strb_q_r && addr_strobe_n;

	// capture at the leading edge: the source holds address and data while low
	assign load = strb_fall; // RULE14
	assign xfer = load && elem_en[clpl_pkg::EL_XFER]; // RULE7 RULE15

	// one-hot decode through the software strap map
	clpl_decode u_decode (
		.byte_addr(byte_addr),
		.addr_map(map_r),
		.elem_en(elem_en)
	); // RULE6 RULE12

	// control lines picked per function by two-bit selects
	for (genvar f = 0; f < 4; f++) begin : g_ctrl
		assign ctrl_val[f] = prog_data[order_r[f*2 +: 2]]; // RULE11
	end

	////////////////////////////////////////////////////////////////////////////////
	// next input register: only the enabled element changes
	always_comb begin
		in_nxt = in_r; // RULE16
		if (load) begin
			if (elem_en[clpl_pkg::EL_AMP_OVR]) begin
				in_nxt.amp_ovr = prog_data[0]; // RULE4 RULE5 RULE9
			end
			for (int k = 0; k < 6; k++) begin
				if (elem_en[clpl_pkg::EL_AMP_BOTTOM - 4'(k)]) begin
					in_nxt.amp_dig[k] = prog_data; // RULE9
				end
			end
			if (elem_en[clpl_pkg::EL_AMP_RNG]) begin
				in_nxt.amp_rng = prog_data[2:0]; // RULE3 RULE5 RULE9
			end
			if (elem_en[clpl_pkg::EL_FRQ_OVR]) begin
				in_nxt.frq_ovr = prog_data[0]; // RULE4 RULE5 RULE10
			end
			for (int k = 0; k < 4; k++) begin
				if (elem_en[clpl_pkg::EL_FRQ_BOTTOM - 4'(k)]) begin
					in_nxt.frq_dig[k] = prog_data; // RULE8 RULE10
				end
			end
			if (elem_en[clpl_pkg::EL_FRQ_RNG]) begin
				in_nxt.frq_rng = prog_data[2:0]; // RULE3 RULE5 RULE8
			end
			if (elem_en[clpl_pkg::EL_CTRL]) begin
				in_nxt.ctrl = ctrl_val; // RULE8 RULE11
			end
		end
		// spare bits forced low so the word registers read back zero there
		in_nxt.spare = 2'h0;
	end

	// input register and strobe history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_r <= '0; // RULE18
			strb_q_r <= 1'b1;
		end else begin
			in_r <= in_nxt;
			strb_q_r <= addr_strobe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// applied word: changes only on the transfer command; the input
	// register's own value is used since the transfer strobe carries no data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_word <= '0; // RULE18
			amp_decade <= 7'h01;
		end else if (xfer) begin
			prog_word <= in_r; // RULE15
			// code zero falls onto the millivolt decade like code one
			amp_decade <= (in_r.amp_rng == 3'h0) ? 7'h01 : 7'(7'h01 << (in_r.amp_rng - 3'h1)); // RULE1 RULE2
		end
	end

	// loaded but not yet committed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_r <= 1'b0;
		end else if (xfer) begin
			pending_r <= 1'b0;
		end else if (load) begin
			pending_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// settle timer starts when the strobe ends; the applied frequency range
	// is already updated by then when the strobe was the transfer command;
	// limitation: a strobe during settling restarts the full time, so a
	// stream of strobes keeps ready low until the last one ends
	clpl_settle #(
		.SHORT_CYC(SHORT_CYC),
		.LONG_CYC(LONG_CYC)
	) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.start(strb_rise),
		.long_sel(prog_word.frq_rng == clpl_pkg::FRQ_RNG_LOWEST),
		.ready(settle_ready)
	); // RULE17

	// ready flag out and its history for the settled event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_flag <= 1'b1;
			ready_q_r <= 1'b1;
		end else begin
			ready_flag <= settle_ready; // RULE17
			ready_q_r <= settle_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt events; a new event beats a write-one-to-clear
	assign events[clpl_pkg::INT_STROBE] = load;
	assign events[clpl_pkg::INT_XFER] = xfer;
	assign events[clpl_pkg::INT_SETTLED] = settle_ready && !ready_q_r;
	assign int_nxt = (int_r & ~((wr_fire && sel_int) ? pwdata[2:0] : 3'h0)) | events;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			int_r <= int_nxt;
			irq <= |(int_r & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb: one wait state; writes land at the edge that completes the transfer
	// the wait state lets the read mux settle into a flop, so prdata comes
	// straight from a register; the cost is one extra cycle per access
	assign apb_access = psel && penable && !pready;
	assign apb_done = psel && penable && pready;
	assign wr_fire = apb_done && pwrite;

	// address decode
	assign sel_map_lo = (paddr == clpl_pkg::REG_MAP_LO);
	assign sel_map_hi = (paddr == clpl_pkg::REG_MAP_HI);
	assign sel_order = (paddr == clpl_pkg::REG_CTRL_ORDER);
	assign sel_status = (paddr == clpl_pkg::REG_STATUS);
	assign sel_int = (paddr == clpl_pkg::REG_INT_STAT);
	assign sel_mask = (paddr == clpl_pkg::REG_INT_MASK);
	assign sel_word_lo = (paddr == clpl_pkg::REG_WORD_LO);
	assign sel_word_hi = (paddr == clpl_pkg::REG_WORD_HI);
	assign sel_any = sel_map_lo || sel_map_hi || sel_order || sel_status ||
		sel_int || sel_mask || sel_word_lo || sel_word_hi;

	// read mux; unmapped reads return zero with an error
	always_comb begin
		if (sel_map_lo) begin
			rdata_nxt = map_r[31:0];
		end else if (sel_map_hi) begin
			rdata_nxt = map_r[63:32];
		end else if (sel_order) begin
			rdata_nxt = {24'h0, order_r};
		end else if (sel_status) begin
			rdata_nxt = {30'h0, pending_r, ready_flag};
		end else if (sel_int) begin
			rdata_nxt = {29'h0, int_r};
		end else if (sel_mask) begin
			rdata_nxt = {29'h0, mask_r};
		end else if (sel_word_lo) begin
			rdata_nxt = prog_word[31:0];
		end else if (sel_word_hi) begin
			rdata_nxt = {10'h0, prog_word[53:32]};
		end else begin
			rdata_nxt = 32'h0;
		end
		rerr_nxt = !sel_any;
	end

	// bus handshake flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_access;
			prdata <= apb_access ? rdata_nxt : 32'h0;
			pslverr <= apb_access && rerr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// writable configuration; a changed map acts on the next strobe only
	// the map is not checked for duplicates: two addresses strapped to one
	// element both load it, and an element with no address never loads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			map_r <= clpl_pkg::MAP_RST; // RULE7 RULE8 RULE9 RULE10
			order_r <= clpl_pkg::CTRL_ORDER_RST;
			mask_r <= clpl_pkg::INT_MASK_RST;
		end else if (wr_fire) begin
			if (sel_map_lo) begin
				map_r[31:0] <= pwdata; // RULE12 RULE13
			end
			if (sel_map_hi) begin
				map_r[63:32] <= pwdata; // RULE12 RULE13
			end
			if (sel_order) begin
				order_r <= pwdata[7:0]; // RULE11
			end
			if (sel_mask) begin
				mask_r <= pwdata[2:0];
			end
		end
	end

endmodule : clpl_loader

// *** clpl_loader_properties.sv ***
// port-level checks for the program loader, bound into clpl_loader
module clpl_chk #(
	parameter int SHORT_CYC = clpl_pkg::SETTLE_SHORT_CYC,
	parameter int LONG_CYC = clpl_pkg::SETTLE_LONG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] byte_addr,
	input wire logic [3:0] prog_data,
	input wire logic addr_strobe_n,
	input wire clpl_pkg::clpl_word_t prog_word,
	input wire logic [6:0] amp_decade,
	input wire logic ready_flag,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic sn_r;
	logic take;
	int since_r;
	int lim;
	/////////////////////////////////////////
	// strobe history, cycles since strobe end, expected settle length
	assign take = !addr_strobe_n && sn_r;
	assign lim = (prog_word.frq_rng == 3'h0) ? LONG_CYC : SHORT_CYC;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sn_r <= 1'b1;
			since_r <= 0;
		end else begin
			sn_r <= addr_strobe_n;
			since_r <= (addr_strobe_n && !sn_r) ? 0 : since_r + 1;
		end
	end
	/////////////////////////////////////////
	a_word_on_take: assert property (!$stable(prog_word) |-> $past(take))
		else $error("applied word moved without a strobe");
	a_decade_onehot: assert property ($onehot(amp_decade))
		else $error("decade not one-hot");
	a_decade_code: assert property (amp_decade == ((prog_word.amp_rng == 3'h0) ? 7'h01 :
		7'h01 << (prog_word.amp_rng - 3'h1))) else $error("decade does not match range code");
	a_spare_zero: assert property (prog_word.spare == 2'h0)
		else $error("spare word bits set");
	a_ready_fall: assert property ($rose(addr_strobe_n) |-> ##[1:3] !ready_flag)
		else $error("ready did not drop after strobe");
	a_settle_len: assert property ($rose(ready_flag) |-> since_r inside {[lim + 1:lim + 3]})
		else $error("settle length wrong");
	a_apb_wait: assert property ($rose(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait");
	a_apb_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_apb_err: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1C))
		else $error("slave error wrong for address");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero when idle");
	c_xfer: cover property (take && byte_addr == 4'hF);
	c_settled: cover property ($rose(ready_flag));
	c_err: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule : clpl_chk

bind clpl_loader clpl_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) i_clpl_chk (.pclk, .presetn,
	.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .byte_addr, .prog_data,
	.addr_strobe_n, .prog_word, .amp_decade, .ready_flag, .irq);

// *** clpl_src.sv ***
// remote programming source: byte address, data nibble, active-low strobe
module clpl_src (
	input wire logic pclk,
	output logic [3:0] byte_addr,
	output logic [3:0] prog_data,
	output logic addr_strobe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOW_CYC = 8; // 800 ns at 100 ns per cycle
	initial begin
		byte_addr = 4'h0;
		prog_data = 4'h0;
		addr_strobe_n = 1'b1;
	end
	// lines held over the whole low strobe, then turned to junk
	task automatic send(input logic [3:0] a, input logic [3:0] d);
		byte_addr <= a;
		prog_data <= d;
		@(posedge pclk);
		addr_strobe_n <= 1'b0;
		repeat (LOW_CYC) @(posedge pclk);
		addr_strobe_n <= 1'b1;
		byte_addr <= ~a;
		prog_data <= ~d;
		@(posedge pclk);
	endtask : send
endmodule : clpl_src

// *** clpl_loader_tb_top.sv ***
// self-checking bench for the program loader
module clpl_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SHORT = 20;
	localparam int LONG = 50;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, ready_flag, irq, addr_strobe_n, err;
	logic [7:0] paddr, ord;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] byte_addr, prog_data;
	logic [6:0] amp_decade;
	clpl_pkg::clpl_word_t prog_word, pend, ew;
	logic [31:0] rv [6] = '{32'h76543210, 32'hFEDCBA98, 32'hE4, 32'h1, 32'h0, 32'h0};
	int n_fail = 0;
	int check_count = 0;
	always #50 pclk = ~pclk;
	clpl_loader #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) i_clpl_loader (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .byte_addr, .prog_data,
		.addr_strobe_n, .prog_word, .amp_decade, .ready_flag, .irq);
	clpl_src i_clpl_src (.pclk, .byte_addr, .prog_data, .addr_strobe_n);
	/////////////////////////////////////////
	// expected word after one byte lands in element el
	function automatic clpl_pkg::clpl_word_t upd(clpl_pkg::clpl_word_t w, logic [3:0] el,
		logic [3:0] d, logic [7:0] o);
		case (el)
			4'h0: w.amp_ovr = d[0];
			4'h7: w.amp_rng = d[2:0];
			4'h8: w.frq_ovr = d[0];
			4'hD: w.frq_rng = d[2:0];
			4'hE: for (int f = 0; f < 4; f++) w.ctrl[f] = d[o[2*f+:2]];
			default: if (el < 4'h7) w.amp_dig[6-el] = d; else if (el < 4'hD) w.frq_dig[12-el] = d;
		endcase
		return w;
	endfunction : upd
	function automatic logic [6:0] dec(logic [2:0] r);
		return (r == 3'h0) ? 7'h01 : 7'h01 << (r - 3'h1);
	endfunction : dec
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	/////////////////////////////////////////
	// one apb transfer; an idle edge first keeps back-to-back calls clean
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			k++;
			if (k > 20) begin
				n_fail++;
				summarize();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// ready-low cycles after a strobe; bounded so a stuck flag ends the run
	task automatic settle(output int lo);
		int k;
		lo = 0;
		for (k = 0; k < 200; k++) begin
			@(posedge pclk);
			if (ready_flag === 1'b0) lo++;
			else if (lo > 0 || k > 3) break;
		end
		if (k == 200) begin
			n_fail++;
			summarize();
		end
	endtask : settle
	task automatic put(input logic [3:0] a, input logic [3:0] el, input logic [3:0] d);
		i_clpl_src.send(a, d);
		pend = upd(pend, el, d, ord);
	endtask : put
	// waits out earlier settling so the next count starts clean
	task automatic commit();
		int lo;
		settle(lo);
		i_clpl_src.send(4'hF, 4'($urandom()));
		ew = pend;
	endtask : commit
	/////////////////////////////////////////
	initial begin
		int lo;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pend = '0;
		ew = '0;
		ord = 8'hE4;
		void'($urandom(16120));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("word", 64'(ew), 64'(prog_word));
		chk("decade", 64'h01, 64'(amp_decade));
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset reg", 64'(rv[i]), 64'(rd));
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 64'h1, 64'(err));
		$display("done: reset and registers");
		apb(1'b1, 8'h14, 32'h2);
		for (int i = 0; i < 15; i++) put(4'(i), 4'(i), 4'($urandom()));
		chk("uncommitted", 64'(ew), 64'(prog_word));
		apb(1'b0, 8'h0C, 32'h0);
		chk("pending", 64'h2, 64'(rd));
		commit();
		chk("full word", 64'(ew), 64'(prog_word));
		chk("irq", 64'h1, 64'(irq));
		settle(lo);
		chk("settle", 64'(ew.frq_rng == 3'h0 ? LONG : SHORT), 64'(lo));
		apb(1'b0, 8'h18, 32'h0);
		chk("word lo", 64'(ew[31:0]), 64'(rd));
		apb(1'b0, 8'h1C, 32'h0);
		chk("word hi", 64'(ew[53:32]), 64'(rd));
		apb(1'b1, 8'h14, 32'h0);
		// mask lands at the closing edge, irq follows one cycle later
		repeat (2) @(posedge pclk);
		chk("irq masked", 64'h0, 64'(irq));
		apb(1'b0, 8'h10, 32'h0);
		chk("int stat", 64'h7, 64'(rd));
		apb(1'b1, 8'h10, 32'h7);
		apb(1'b0, 8'h10, 32'h0);
		chk("int cleared", 64'h0, 64'(rd));
		$display("done: full load");
		for (int i = 0; i < 8; i++) begin
			put(4'h7, 4'h7, {1'($urandom()), 3'(i)});
			put(4'hD, 4'hD, {1'($urandom()), 3'(i % 5)});
			commit();
			chk("range word", 64'(ew), 64'(prog_word));
			chk("decade", 64'(dec(3'(i))), 64'(amp_decade));
			settle(lo);
			chk("settle", 64'(i % 5 == 0 ? LONG : SHORT), 64'(lo));
		end
		$display("done: ranges");
		apb(1'b1, 8'h00, 32'hD6543210);
		apb(1'b1, 8'h04, 32'hFE7CBA98);
		put(4'hD, 4'h7, {1'($urandom()), 3'h5});
		put(4'h7, 4'hD, {1'($urandom()), 3'h3});
		commit();
		chk("swapped", 64'(ew), 64'(prog_word));
		ord = 8'h1B;
		apb(1'b1, 8'h08, 32'(ord));
		for (int i = 0; i < 4; i++) begin
			put(4'hE, 4'hE, 4'($urandom()));
			commit();
			chk("ctrl order", 64'(ew), 64'(prog_word));
		end
		$display("done: remap and control order");
		summarize();
	end
endmodule : clpl_loader_tb_top
